// file: pdc_pkg.sv
/*
 * Shared constants and carrier types for the power device control register bank.
 * Assumes a single 25 MHz clock domain shared with the serial-port register engine.
 */
`default_nettype none

package pdc_pkg;

	// register offsets
	localparam logic [7:0] ADDR_CONV = 8'h3e;
	localparam logic [7:0] ADDR_DEV  = 8'h3f;

	// converter control field positions
	localparam int CONV_RSVD_BIT  = 7;
	localparam int TRACK_BIT      = 6;
	localparam int SKIP_HI        = 5;
	localparam int SKIP_LO        = 3;
	localparam int PAD_SEL_BIT    = 2;
	localparam int SYNC_HI        = 1;
	localparam int SYNC_LO        = 0;

	// device control field positions
	localparam int OFF_SEQ_BIT    = 7;
	localparam int RTC_PD_BIT     = 6;
	localparam int SLOW_RC_BIT    = 5;
	localparam int SCALE_PORT_BIT = 4;
	localparam int OFF_RST_BIT    = 3;
	localparam int KEEP_ON_BIT    = 2;
	localparam int SLEEP_BIT      = 1;
	localparam int OFF_BIT        = 0;

	// reset values
	localparam logic       TRACK_RST      = 1'h0;
	localparam logic [2:0] SKIP_RST       = 3'h7;
	localparam logic       PAD_SEL_RST    = 1'h0;
	localparam logic [1:0] SYNC_RST       = 2'h1;
	localparam logic       OFF_SEQ_RST    = 1'h0;
	localparam logic       RTC_PD_RST     = 1'h0;
	localparam logic       SLOW_RC_RST    = 1'h0;
	localparam logic       SCALE_PORT_RST = 1'h1;
	localparam logic       OFF_RST_RST    = 1'h0;
	localparam logic       KEEP_ON_RST    = 1'h0;
	localparam logic       SLEEP_RST      = 1'h0;
	localparam logic       OFF_REQ_RST    = 1'h0;

	// converter clock sync codes
	localparam logic [1:0] SYNC_PHASE   = 2'h1;
	localparam logic [1:0] SYNC_INPHASE = 2'h3;

	// request from the serial-port register engine
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_req_t;

	// converter settings handed to the regulators
	typedef struct packed {
		logic       trackEn;
		logic       coreBuckTwoSkipEn;
		logic       coreBuckOneSkipEn;
		logic       ioBuckSkipEn;
		logic       syncPadSelect;
		logic       convSyncEn;
		logic       convPhaseShift;
	} conv_cfg_t;

	// power-state commands handed to the state machine
	typedef struct packed {
		logic       sequentialOffEn;
		logic       rtcClockGate;
		logic       rtcResetHold;
		logic       slowClockRc;
		logic       scalingPortCtl;
		logic       keepOn;
		logic       sleepAllow;
		logic       coreResetReq;
	} dev_cmd_t;

endpackage : pdc_pkg

`default_nettype wire

// file: pad_sync.sv
/*
 * Two-flop synchroniser for the shared sync pad level.
 * Assumes the pad toggles freely with respect to clk.
 */
`default_nettype none

module pad_sync
(
	// clocking
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	// pad side
	input  wire logic padIn,
	output logic      padSync
);

	logic meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta    <= 1'h0;
			padSync <= 1'h0;
		end
		else if (ce)
		begin
			meta    <= padIn;
			padSync <= meta;
		end
	end

endmodule : pad_sync

`default_nettype wire

// file: power_device_control_regs.sv
/*
 * Converter control and device control registers of the power unit.
 * Assumes the serial-port engine presents one-cycle register requests on clk,
 * the power state machine flags the off state, and the boot image is stable.
 */
`default_nettype none

module power_device_control_regs
	import pdc_pkg::*;
(
	// clocking and resets
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire logic      rstTurnoff,
	input  wire logic      ce,
	// register port from the serial engine
	input  wire reg_req_t  req,
	output logic [7:0]     rdData,
	output logic           rdValid,
	// boot image and state machine
	input  wire logic [2:0] bootSkip,
	input  wire logic      bootSlowRc,
	input  wire logic      bootKeepOn,
	input  wire logic      offReached,
	// shared sync pad
	input  wire logic      padIn,
	output logic           padGpioIn,
	output logic           padExtClk,
	// control outputs
	output conv_cfg_t      convCfg,
	output dev_cmd_t       devCmd,
	output logic           offPulse,
	output logic           wakePulse
);

	logic       track;
	logic [2:0] skip;
	logic       padSel;
	logic [1:0] syncMode;
	logic       offSeq;
	logic       rtcPd;
	logic       slowRc;
	logic       scalePort;
	logic       offRst;
	logic       keepOn;
	logic       sleepAllow;
	logic       offReq;
	logic       bootPendOff;
	logic       bootPendGen;
	logic       padSync;
	logic       wrConv;
	logic       wrDev;
	logic       offAny;

	assign wrConv = ce && req.wr && (req.addr == ADDR_CONV);
	assign wrDev  = ce && req.wr && (req.addr == ADDR_DEV);
	assign offAny = offReq || offRst;

	// turn-off domain: tracking, skip enables and rtc gate survive general resets
	always_ff @(posedge clk or posedge rstTurnoff)
	begin
		if (rstTurnoff)
		begin
			track       <= TRACK_RST;
			skip        <= SKIP_RST;
			rtcPd       <= RTC_PD_RST;
			bootPendOff <= 1'h1;
		end
		else if (ce)
		begin
			bootPendOff <= 1'h0;
			if (wrConv)
			begin
				track <= req.data[TRACK_BIT];
				skip  <= req.data[SKIP_HI:SKIP_LO];
			end
			else if (bootPendOff)
				skip <= bootSkip;
			if (wrDev)
				rtcPd <= req.data[RTC_PD_BIT];
		end
	end

	// general domain converter bits
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			padSel   <= PAD_SEL_RST;
			syncMode <= SYNC_RST;
		end
		else if (wrConv)
		begin
			padSel   <= req.data[PAD_SEL_BIT];
			syncMode <= req.data[SYNC_HI:SYNC_LO];
		end
	end

	// device control configuration bits
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			offSeq      <= OFF_SEQ_RST;
			slowRc      <= SLOW_RC_RST;
			scalePort   <= SCALE_PORT_RST;
			keepOn      <= KEEP_ON_RST;
			bootPendGen <= 1'h1;
		end
		else if (ce)
		begin
			bootPendGen <= 1'h0;
			if (wrDev)
			begin
				offSeq    <= req.data[OFF_SEQ_BIT];
				slowRc    <= req.data[SLOW_RC_BIT];
				scalePort <= req.data[SCALE_PORT_BIT];
				keepOn    <= req.data[KEEP_ON_BIT];
			end
			else if (bootPendGen)
			begin
				slowRc <= bootSlowRc;
				keepOn <= bootKeepOn;
			end
		end
	end

	// power-state commands; a write in the same cycle as offReached wins
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			offRst     <= OFF_RST_RST;
			sleepAllow <= SLEEP_RST;
			offReq     <= OFF_REQ_RST;
		end
		else if (ce)
		begin
			if (wrDev)
			begin
				offRst     <= req.data[OFF_RST_BIT];
				sleepAllow <= req.data[SLEEP_BIT];
				offReq     <= req.data[OFF_BIT];
			end
			else if (offReached)
			begin
				offRst     <= 1'h0;
				sleepAllow <= 1'h0;
				offReq     <= 1'h0;
			end
		end
	end

	// event pulses; wake only when the write leaves both off bits clear
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			offPulse  <= 1'h0;
			wakePulse <= 1'h0;
		end
		else if (ce)
		begin
			offPulse  <= wrDev && (req.data[OFF_BIT] || req.data[OFF_RST_BIT]);
			wakePulse <= wrDev && sleepAllow && !req.data[SLEEP_BIT]
				&& !req.data[OFF_BIT] && !req.data[OFF_RST_BIT];
		end
	end

	// registered read data, one cycle after the request
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdData  <= 8'h00;
			rdValid <= 1'h0;
		end
		else if (ce)
		begin
			rdValid <= req.rd;
			if (req.rd && req.addr == ADDR_CONV)
				rdData <= {1'h0, track, skip, padSel, syncMode};
			else if (req.rd && req.addr == ADDR_DEV)
				rdData <= {offSeq, rtcPd, slowRc, scalePort, offRst, keepOn, sleepAllow, offReq};
			else if (req.rd)
				rdData <= 8'h00;  // unmapped reads return zero
		end
	end

	pad_sync u_padSync
	(
		.clk     (clk),
		.rst     (rst),
		.ce      (ce),
		.padIn   (padIn),
		.padSync (padSync)
	);

	// pad mux: the unused branch reads low so nothing sees a stray clock
	assign padGpioIn = padSel ? 1'h0 : padSync;
	assign padExtClk = padSel ? padSync : 1'h0;

	// converter outputs
	assign convCfg.trackEn           = track;
	assign convCfg.coreBuckTwoSkipEn = skip[2];
	assign convCfg.coreBuckOneSkipEn = skip[1];
	assign convCfg.ioBuckSkipEn      = skip[0];
	assign convCfg.syncPadSelect     = padSel;
	assign convCfg.convSyncEn        = syncMode[0];
	assign convCfg.convPhaseShift    = (syncMode == SYNC_PHASE);

	// device commands; off requests mask keep-on and sleep
	assign devCmd.sequentialOffEn = offSeq;
	assign devCmd.rtcClockGate    = rtcPd;
	assign devCmd.rtcResetHold    = rtcPd;
	assign devCmd.slowClockRc     = slowRc;
	assign devCmd.scalingPortCtl  = scalePort;
	assign devCmd.keepOn          = keepOn && !offAny;
	assign devCmd.sleepAllow      = sleepAllow && !offAny;
	assign devCmd.coreResetReq    = offRst;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || rstTurnoff);

	a_conv_readback: assert property (ce && req.rd && req.addr == ADDR_CONV ##1 1 |->
		rdValid && rdData[CONV_RSVD_BIT] == 1'h0)
		else $error("converter bit 7 not zero");
	a_track_write: assert property (wrConv |=> convCfg.trackEn == $past(req.data[TRACK_BIT]))
		else $error("tracking bit not stored");
	a_skip_write: assert property (wrConv |=> skip == $past(req.data[SKIP_HI:SKIP_LO]))
		else $error("skip bits not stored");
	a_pad_mux: assert property (padSel |-> !padGpioIn)
		else $error("pad read as gpio in clock mode");
	a_sync_decode: assert property (convCfg.convSyncEn == (syncMode == SYNC_PHASE
		|| syncMode == SYNC_INPHASE))
		else $error("sync decode wrong");
	a_off_clear: assert property (ce && offReached && !wrDev |=> !offReq && !offRst && !sleepAllow)
		else $error("off bits not cleared");
	a_write_wins: assert property (wrDev && offReached && req.data[OFF_BIT] |=> offReq)
		else $error("off write lost");
	a_keep_masked: assert property (offAny |-> !devCmd.keepOn && !devCmd.sleepAllow)
		else $error("keep-on not masked by off");
	a_wake_pulse: assert property (wrDev && sleepAllow && !req.data[SLEEP_BIT]
		&& !req.data[OFF_BIT] && !req.data[OFF_RST_BIT]
		|=> wakePulse ##1 (!wakePulse || !$past(ce)))
		else $error("wake pulse missing");
	a_rtc_gate: assert property (wrDev |=> devCmd.rtcClockGate == $past(req.data[RTC_PD_BIT])
		&& devCmd.rtcResetHold == devCmd.rtcClockGate)
		else $error("rtc gate and reset disagree");
	a_scale_write: assert property (wrDev |=> devCmd.scalingPortCtl == $past(req.data[SCALE_PORT_BIT]))
		else $error("scaling port bit not stored");

	c_off_write:   cover property (wrDev && req.data[OFF_BIT] ##[1:20] offReached);
	c_wake:        cover property (wakePulse);
	c_ext_clock:   cover property (padSel && padExtClk);
	c_conv_read:   cover property (rdValid && rdData != 8'h00);

endmodule : power_device_control_regs

`default_nettype wire

// file: off_state_model.sv
/*
 * Behavioural power state machine that answers off requests.
 * Assumes offPulse is a one-cycle pulse on clk; lag sets how slowly off is reached.
 */
`default_nettype none

module off_state_model
(
	// clocking
	input  wire logic       clk,
	input  wire logic       rst,
	// request side
	input  wire logic       offPulse,
	input  wire logic [3:0] lag,
	// state flag
	output logic            offReached
);
	logic [4:0] cnt;

	// off state is flagged for one cycle only, so the stretch is shortest
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt        <= 5'h0;
			offReached <= 1'h0;
		end
		else
		begin
			if (offPulse)
				cnt <= {1'h0, lag} + 5'h1;
			else if (cnt != 5'h0)
				cnt <= cnt - 5'h1;
			offReached <= (cnt == 5'h1);
		end
	end
endmodule : off_state_model

`default_nettype wire

// file: test_power_device_control_regs.sv
/*
 * Self-checking bench for the converter and device control registers.
 * Assumes the register port takes one-cycle strobes and the state model flags off.
 */
`default_nettype none

module test_power_device_control_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import pdc_pkg::*;

	logic       clk, rst, rstTurnoff, ce, offReached, padIn, bootSlowRc, bootKeepOn;
	logic [2:0] bootSkip;
	logic [3:0] lag;
	logic [7:0] rdData, d, devRst;
	logic       rdValid, padGpioIn, padExtClk, offPulse, wakePulse;
	reg_req_t   req;
	conv_cfg_t  convCfg;
	dev_cmd_t   devCmd;
	int         nErrors, checksDone, i;

	power_device_control_regs dut (.clk(clk), .rst(rst), .rstTurnoff(rstTurnoff), .ce(ce),
		.req(req), .rdData(rdData), .rdValid(rdValid), .bootSkip(bootSkip),
		.bootSlowRc(bootSlowRc), .bootKeepOn(bootKeepOn), .offReached(offReached),
		.padIn(padIn), .padGpioIn(padGpioIn), .padExtClk(padExtClk), .convCfg(convCfg),
		.devCmd(devCmd), .offPulse(offPulse), .wakePulse(wakePulse));

	off_state_model model (.clk(clk), .rst(rst), .offPulse(offPulse), .lag(lag),
		.offReached(offReached));

	task summarize;
		$display("errors=%0d checks=%0d", nErrors, checksDone);
		if (nErrors == 0 && checksDone > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			nErrors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// strobes last one cycle, so outputs are settled at the closing falling edge
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		req.wr   = 1'h1;
		req.addr = a;
		req.data = v;
		@(negedge clk);
		req.wr = 1'h0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		req.rd   = 1'h1;
		req.addr = a;
		@(negedge clk);
		req.rd = 1'h0;
		chk({7'h0, rdValid}, 8'h1);
		chk(rdData, exp);
	endtask : rd

	task doReset(input logic both);
		rst = 1'h1;
		rstTurnoff = both;
		repeat (5) @(negedge clk);
		rst = 1'h0;
		rstTurnoff = 1'h0;
		repeat (2) @(negedge clk);
	endtask : doReset

	// sync field decodes to enable and phase shift
	function automatic logic [7:0] expConv(input logic [7:0] v);
		return {1'h0, v[6:2], v[0], v[1:0] == SYNC_PHASE};
	endfunction : expConv

	initial
	begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	// hang guard, far beyond the longest sequence
	initial
	begin
		#800000;
		nErrors++;
		summarize();
	end

	initial
	begin
		void'($urandom(32'h4b645ca3));
		nErrors = 0;
		checksDone = 0;
		ce = 1'h1;
		padIn = 1'h0;
		req = '0;
		lag = 4'h0;
		{bootSkip, bootSlowRc, bootKeepOn} = 5'($urandom);
		doReset(1'h1);
		devRst = {2'h0, bootSlowRc, 1'h1, 1'h0, bootKeepOn, 2'h0};
		rd(ADDR_CONV, {2'h0, bootSkip, 3'h1});
		rd(ADDR_DEV, devRst);
		rd(8'h3d, 8'h00);
		for (i = 0; i < 40; i++)
		begin
			d = {6'($urandom), 2'(i)};
			wr(ADDR_CONV, d);
			chk({1'h0, convCfg}, expConv(d));
			rd(ADDR_CONV, {1'h0, d[6:0]});
		end
		for (i = 0; i < 20; i++)
		begin
			d = 8'($urandom) & 8'hf6;
			wr(ADDR_DEV, d);
			chk(devCmd, {d[7], d[6], d[6], d[5], d[4], d[2], d[1], 1'h0});
			rd(ADDR_DEV, d);
		end
		wr(ADDR_DEV, 8'h12);
		wr(ADDR_DEV, 8'h10);
		chk({7'h0, wakePulse}, 8'h1);
		wr(ADDR_DEV, 8'h12);
		// off and wake together: off must win
		wr(ADDR_DEV, 8'h11);
		chk({6'h0, wakePulse, offPulse}, 8'h1);
		for (i = 0; i < 3; i++)
		begin
			if (i > 0)
			begin
				lag = 4'($urandom);
				d = (i == 2) ? 8'h0e : 8'h07;
				wr(ADDR_DEV, d);
				chk({offPulse, devCmd.keepOn, devCmd.sleepAllow, devCmd.coreResetReq},
					{4'h0, 2'h2, 1'h0, d[3]});
			end
			for (int k = 0; k < 40 && offReached !== 1'h1; k++)
				@(negedge clk);
			if (offReached !== 1'h1)
			begin
				nErrors++;
				summarize();
			end
			@(negedge clk);
			rd(ADDR_DEV, (i == 0) ? 8'h10 : 8'h04);
		end
		// off write landing on the off-reached edge: the write must win
		lag = 4'h0;
		wr(ADDR_DEV, 8'h01);
		@(negedge clk);
		wr(ADDR_DEV, 8'h05);
		chk({6'h0, offPulse, devCmd.keepOn}, 8'h2);
		repeat (4) @(negedge clk);
		rd(ADDR_DEV, 8'h04);
		// general reset must spare the turn-off domain
		wr(ADDR_CONV, 8'hff);
		wr(ADDR_DEV, 8'h40);
		doReset(1'h0);
		rd(ADDR_CONV, 8'h79);
		rd(ADDR_DEV, devRst | 8'h40);
		padIn = 1'h1;
		wr(ADDR_CONV, 8'h00);
		repeat (3) @(negedge clk);
		chk({6'h0, padGpioIn, padExtClk}, 8'h2);
		wr(ADDR_CONV, 8'h04);
		chk({6'h0, padGpioIn, padExtClk}, 8'h1);
		padIn = 1'h0;
		repeat (3) @(negedge clk);
		chk({6'h0, padGpioIn, padExtClk}, 8'h0);
		// clock enable low: the strobe is ignored and all state frozen
		ce = 1'h0;
		wr(ADDR_CONV, 8'h7b);
		ce = 1'h1;
		rd(ADDR_CONV, 8'h04);
		summarize();
	end
endmodule : test_power_device_control_regs

`default_nettype wire
